// ==== bus_defines.svh ====
// constants shared by both ends of the processor local bus
`ifndef BUS_DEFINES_SVH
`define BUS_DEFINES_SVH

// ----------------------------------------------------------------
// lane layout
// ----------------------------------------------------------------
`define LANES           4
`define LANE_BITS       8

// ----------------------------------------------------------------
// cycle type codes, memory/io, data/control, write/read order
// ----------------------------------------------------------------
`define CODE_INTACK     3'h0
`define CODE_HALT       3'h1
`define CODE_IO_RD      3'h2
`define CODE_IO_WR      3'h3
`define CODE_CODE_RD    3'h4
`define CODE_RESERVED   3'h5
`define CODE_MEM_RD     3'h6
`define CODE_MEM_WR     3'h7

// ----------------------------------------------------------------
// transfer sizes and lane masks
// ----------------------------------------------------------------
`define LINE_BEATS      3'h4
`define MASK_BYTE       4'h1
`define MASK_HALF       4'h3
`define MASK_FULL       4'hf
`define DATA_IDLE       32'hffffffff
`define PAR_IDLE        4'hf

`endif

// ==== bus_pkg.sv ====
// types and shared functions of the processor local bus
package bus_pkg;
`include "bus_defines.svh"

	// ----------------------------------------------------------------
	// cycle types and sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CYC_INTACK   = `CODE_INTACK,
		CYC_HALT     = `CODE_HALT,
		CYC_IO_RD    = `CODE_IO_RD,
		CYC_IO_WR    = `CODE_IO_WR,
		CYC_CODE_RD  = `CODE_CODE_RD,
		CYC_RESERVED = `CODE_RESERVED,
		CYC_MEM_RD   = `CODE_MEM_RD,
		CYC_MEM_WR   = `CODE_MEM_WR
	} cyc_type_e;

	typedef enum logic [1:0] {
		DS_IDLE = 2'b00,
		DS_T1   = 2'b01,
		DS_T2   = 2'b10,
		DS_HOLD = 2'b11
	} dev_state_e;

	// ----------------------------------------------------------------
	// even parity bit per lane, lane 0 is bits 7..0
	// ----------------------------------------------------------------
	function automatic logic [3:0] lane_parity(input logic [31:0] d);
		logic [3:0] p;
		p = 4'h0;
		for (int i = 0; i < `LANES; i++) begin
			p[i] = ^d[`LANE_BITS*i +: `LANE_BITS];
		end
		return p;
	endfunction

endpackage

// ==== local_bus_if.sv ====
// pins of the processor local bus between the processor end and the system end
`timescale 1ns/10ps
interface local_bus_if;
	// ----------------------------------------------------------------
	// data lanes and parity, resolved from the two drivers
	// ----------------------------------------------------------------
	logic [31:0] cpu_d;
	logic [3:0]  cpu_dp;
	logic        cpu_d_oe;
	logic [31:0] sys_d;
	logic [3:0]  sys_dp;
	logic        sys_d_oe;
	logic [31:0] data_lanes;
	logic [3:0]  lane_parity_bits;

	// ----------------------------------------------------------------
	// processor outputs; ctl_oe and addr_oe say when they are driven
	// ----------------------------------------------------------------
	logic        m_io;
	logic        d_c;
	logic        w_r;
	logic        addr_strobe_n;
	logic        final_beat_n;
	logic        multi_cycle_atomic_n;
	logic        atomic_seq_n;
	logic [31:2] word_addr_lines;
	logic [3:0]  lane_enables_n;
	logic        ctl_oe;
	logic        addr_oe;
	logic        hold_ack;
	logic        parity_fault_n;

	// ----------------------------------------------------------------
	// system outputs
	// ----------------------------------------------------------------
	logic        rdy_n;
	logic        burst_ready_n;
	logic        cacheable_in_n;
	logic        hold_req;
	logic        addr_float_req;
	logic        width_sel_byte_n;
	logic        width_sel_half_n;

	// undriven lanes pull up
	assign data_lanes       = cpu_d_oe ? cpu_d : (sys_d_oe ? sys_d : `DATA_IDLE);
	assign lane_parity_bits = cpu_d_oe ? cpu_dp : (sys_d_oe ? sys_dp : `PAR_IDLE);

	modport cpu (
		output cpu_d, cpu_dp, cpu_d_oe, m_io, d_c, w_r, addr_strobe_n, final_beat_n,
		output multi_cycle_atomic_n, atomic_seq_n, word_addr_lines, lane_enables_n,
		output ctl_oe, addr_oe, hold_ack, parity_fault_n,
		input  data_lanes, lane_parity_bits, rdy_n, burst_ready_n, cacheable_in_n,
		input  hold_req, addr_float_req, width_sel_byte_n, width_sel_half_n
	);

	modport sys (
		output sys_d, sys_dp, sys_d_oe, rdy_n, burst_ready_n, cacheable_in_n,
		output hold_req, addr_float_req, width_sel_byte_n, width_sel_half_n,
		input  data_lanes, lane_parity_bits, m_io, d_c, w_r, addr_strobe_n, final_beat_n,
		input  multi_cycle_atomic_n, atomic_seq_n, word_addr_lines, lane_enables_n,
		input  ctl_oe, addr_oe, hold_ack, parity_fault_n
	);
endinterface

// ==== sys_bus_end.sv ====
// system end of the local bus: memory responder with wait states, burst and parity
`timescale 1ns/10ps
module sys_bus_end
	import bus_pkg::*;
#(
	parameter int MEM_AW = 4
) (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RSTN,
	input  wire logic        CE,
	// bus
	local_bus_if.sys         BUS,
	// responder controls
	input  wire logic [3:0]  WAIT_STATES,
	input  wire logic        BURST_EN,
	input  wire logic        KEN_EN,
	input  wire logic [3:0]  PAR_FLIP,
	input  wire logic        HOLD_IN,
	input  wire logic        FLOAT_IN,
	input  wire logic        WIDTH_BYTE,
	input  wire logic        WIDTH_HALF,
	input  wire logic [7:0]  INTACK_VEC,
	// observation
	output logic             CAP_VALID,
	output logic [2:0]       CAP_TYPE,
	output logic [31:2]      CAP_ADDR,
	output logic             PAR_FAULT,
	output logic             HOLD_ACK
);
	logic [31:0] mem_r [2**MEM_AW];
	cyc_type_e   type_r;
	cyc_type_e   type_nxt;
	logic [31:2] baddr_r;
	logic [31:2] baddr_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	logic        waiting_r;
	logic        waiting_nxt;
	logic        rdy_n_r;
	logic        burst_ready_n_n_r;
	logic        d_oe_r;
	logic [31:0] d_r;
	logic [3:0]  dp_r;
	logic        ken_n_r;
	logic        hold_r;
	logic        float_r;
	logic        byte_n_r;
	logic        half_n_r;
	logic        ads_now;
	logic        beat_now;
	logic        over;
	logic        fire;
	logic        use_burst;
	logic [31:0] rdata;

	// ----------------------------------------------------------------
	// cycle tracking
	// ----------------------------------------------------------------
	assign ads_now   = ~BUS.addr_strobe_n & BUS.ctl_oe;
	assign beat_now  = ~rdy_n_r | ~burst_ready_n_n_r;
	assign over      = ~rdy_n_r | (~burst_ready_n_n_r & ~BUS.final_beat_n);
	assign type_nxt  = ads_now ? cyc_type_e'({BUS.m_io, BUS.d_c, BUS.w_r}) : type_r;
	assign baddr_nxt = ads_now ? BUS.word_addr_lines :
		(beat_now & ~over) ? {baddr_r[31:4], 2'(baddr_r[3:2] + 2'h1)} : baddr_r;
	// bursts only where the line was declared cacheable
	assign use_burst = BURST_EN & KEN_EN & ~type_nxt[0];
	assign rdata     = (type_nxt == CYC_INTACK) ? {24'h000000, INTACK_VEC} : mem_r[baddr_nxt[MEM_AW+1:2]];
	assign fire      = waiting_nxt & (cnt_nxt == 4'h0);

	always_comb begin
		waiting_nxt = waiting_r;
		cnt_nxt     = cnt_r;
		if (ads_now | (beat_now & ~over)) begin
			waiting_nxt = 1'b1;
			cnt_nxt     = WAIT_STATES;
		end else if (beat_now) begin
			waiting_nxt = 1'b0;
		end else if (waiting_r & (cnt_r != 4'h0)) begin
			cnt_nxt = cnt_r - 4'h1;
		end
	end

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			type_r    <= CYC_INTACK;
			baddr_r   <= 30'h0;
			cnt_r     <= 4'h0;
			waiting_r <= 1'b0;
		end else if (CE) begin
			type_r    <= type_nxt;
			baddr_r   <= baddr_nxt;
			cnt_r     <= cnt_nxt;
			waiting_r <= waiting_nxt;
		end
	end

	// ----------------------------------------------------------------
	// ready and read data, one beat per assertion
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			rdy_n_r  <= 1'b1;
			burst_ready_n_n_r <= 1'b1;
			d_oe_r   <= 1'b0;
			d_r      <= 32'h0;
			dp_r     <= 4'h0;
		end else if (CE) begin
			rdy_n_r  <= ~(fire & ~use_burst);
			burst_ready_n_n_r <= ~(fire & use_burst);
			d_oe_r   <= fire & ~type_nxt[0];
			d_r      <= rdata;
			dp_r     <= lane_parity(rdata) ^ PAR_FLIP;
		end
	end

	// no reset on the array: contents are don't-care until written
	always_ff @(posedge REF_CLK) begin
		if (CE && beat_now && type_r == CYC_MEM_WR) begin
			for (int i = 0; i < `LANES; i++) begin
				if (!BUS.lane_enables_n[i]) begin
					mem_r[baddr_r[MEM_AW+1:2]][8*i +: 8] <= BUS.data_lanes[8*i +: 8];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// static controls and observation
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ken_n_r   <= 1'b1;
			hold_r    <= 1'b0;
			float_r   <= 1'b0;
			byte_n_r  <= 1'b1;
			half_n_r  <= 1'b1;
			CAP_VALID <= 1'b0;
			CAP_TYPE  <= 3'h0;
			CAP_ADDR  <= 30'h0;
			PAR_FAULT <= 1'b0;
			HOLD_ACK  <= 1'b0;
		end else if (CE) begin
			ken_n_r   <= ~KEN_EN;
			hold_r    <= HOLD_IN;
			float_r   <= FLOAT_IN;
			byte_n_r  <= ~WIDTH_BYTE;
			half_n_r  <= ~WIDTH_HALF;
			CAP_VALID <= ads_now;
			if (ads_now) begin
				CAP_TYPE <= {BUS.m_io, BUS.d_c, BUS.w_r};
				CAP_ADDR <= BUS.word_addr_lines;
			end
			PAR_FAULT <= ~BUS.parity_fault_n;
			HOLD_ACK  <= BUS.hold_ack;
		end
	end

	assign BUS.rdy_n            = rdy_n_r;
	assign BUS.burst_ready_n    = burst_ready_n_n_r;
	assign BUS.sys_d_oe         = d_oe_r;
	assign BUS.sys_d            = d_r;
	assign BUS.sys_dp           = dp_r;
	assign BUS.cacheable_in_n   = ken_n_r;
	assign BUS.hold_req         = hold_r;
	assign BUS.addr_float_req   = float_r;
	assign BUS.width_sel_byte_n = byte_n_r;
	assign BUS.width_sel_half_n = half_n_r;
endmodule

// ==== cpu_bus_end.sv ====
// processor end of the local bus: cycle sequencing, locking, burst and parity
`timescale 1ns/10ps
// Overview of operation
// - 32-bit data, lane 0 least significant
// - data lanes undriven on reads and hold
// - one even parity bit per byte lane
// - write parity driven alongside write data
// - system returns even parity with read data
// - parity fault low clock after read ready
// - check code/memory/io reads, not interrupt acknowledge
// - check only enabled lanes of selected width
// - bad parity only drives the fault pin
// - cycle type valid with address strobe
// - atomic sequence spans first to last ready
// - no hold grant during atomic sequence
// - multi-cycle atomic on 64/128-bit transfers
// - refuse hold between multi-cycle atomic cycles, except non-cacheable code prefetch
// - multi-cycle atomic until final cycle addressed
// - multi-cycle atomic inverse of final beat on reads; writes assert both
// - strobe only in first clock of cycle
// - system captures type edge after strobe
// - ready ends cycle, ignored idle and first
// - burst ready each clock advances address
// - ready with burst ready aborts burst
// - final beat marks the terminating ready
// - cycle lasts at least two clocks
// - lane enable i governs byte lane i
module cpu_bus_end
	import bus_pkg::*;
(
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RSTN,
	input  wire logic        CE,
	// bus
	local_bus_if.cpu         BUS,
	// transfer request
	input  wire logic        REQ_VALID,
	output logic             REQ_READY,
	input  wire logic [2:0]  REQ_TYPE,
	input  wire logic [31:2] REQ_ADDR,
	input  wire logic [3:0]  REQ_BE,
	input  wire logic [63:0] REQ_WDATA,
	input  wire logic [2:0]  REQ_BEATS,
	input  wire logic        REQ_PSEUDO,
	input  wire logic        REQ_LOCK,
	input  wire logic        REQ_LOCK_LAST,
	// read return
	output logic             RD_VALID,
	output logic [31:0]      RD_DATA,
	output logic             DONE
);
	dev_state_e  state_r;
	dev_state_e  state_nxt;
	cyc_type_e   type_r;
	logic [31:2] addr_r;
	logic [3:0]  be_r;
	logic [63:0] wdata_r;
	logic [3:0]  par_r;
	logic [2:0]  beats_r;
	logic [2:0]  beats_nxt;
	logic        pseudo_r;
	logic        lock_last_r;
	logic        fill_r;
	logic        first_t2_r;
	logic        ken_seen_r;
	logic        ads_n_r;
	logic        ctl_oe_r;
	logic        addr_oe_r;
	logic        hold_ack_r;
	logic        d_oe_r;
	logic        final_n_r;
	logic        multi_cycle_atomic_n_n_r;
	logic        lock_n_r;
	logic        parity_fault_n_n_r;
	logic        start;
	logic        rdy_hit;
	logic        burst_ready_n_hit;
	logic        beat_hit;
	logic        ken_miss;
	logic        eff_last;
	logic        xfer_end;
	logic        hold_ok;
	logic        write_nxt;
	logic        pseudo_nxt;
	logic        bus_on_nxt;
	logic [3:0]  lane_mask;
	logic        par_bad;

	function automatic logic [3:0] width_mask(input logic byte_n, input logic half_n);
		if (!byte_n) begin
			return `MASK_BYTE;
		end
		return half_n ? `MASK_FULL : `MASK_HALF;
	endfunction

	// ----------------------------------------------------------------
	// beat decode
	// ----------------------------------------------------------------
	assign rdy_hit  = (state_r == DS_T2) & ~BUS.rdy_n;
	assign burst_ready_n_hit = (state_r == DS_T2) & BUS.rdy_n & ~BUS.burst_ready_n;
	assign beat_hit = rdy_hit | burst_ready_n_hit;
	// a line fill not confirmed cacheable by the first wait clock shrinks to one transfer
	assign ken_miss = fill_r & first_t2_r & BUS.cacheable_in_n;
	assign eff_last = (beats_r == 3'h1) | ken_miss;
	assign xfer_end = beat_hit & eff_last;
	assign hold_ok  = lock_n_r & (~pseudo_r | (type_r == CYC_CODE_RD & ~ken_seen_r));
	assign start    = (state_r == DS_IDLE) & REQ_VALID & REQ_READY & ~(BUS.hold_req & lock_n_r);

	// ----------------------------------------------------------------
	// sequencer
	// ----------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			DS_IDLE: begin
				if (BUS.hold_req & lock_n_r) begin
					state_nxt = DS_HOLD;
				end else if (start) begin
					state_nxt = DS_T1;
				end
			end
			DS_T1: begin
				state_nxt = DS_T2;
			end
			DS_T2: begin
				if (xfer_end) begin
					state_nxt = (BUS.hold_req & (lock_n_r | lock_last_r)) ? DS_HOLD : DS_IDLE;
				end else if (rdy_hit) begin
					state_nxt = (BUS.hold_req & hold_ok) ? DS_HOLD : DS_T1;
				end
			end
			DS_HOLD: begin
				if (!BUS.hold_req) begin
					state_nxt = (beats_r != 3'h0) ? DS_T1 : DS_IDLE;
				end
			end
		endcase
	end

	always_comb begin
		beats_nxt = beats_r;
		if (start) begin
			beats_nxt = REQ_BEATS;
		end else if (xfer_end) begin
			beats_nxt = 3'h0;
		end else if (beat_hit) begin
			beats_nxt = beats_r - 3'h1;
		end else if (ken_miss) begin
			beats_nxt = 3'h1;
		end
	end

	assign write_nxt  = start ? REQ_TYPE[0] : type_r[0];
	assign pseudo_nxt = start ? REQ_PSEUDO : pseudo_r;
	assign bus_on_nxt = (state_nxt == DS_T1) | (state_nxt == DS_T2);

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= DS_IDLE;
		end else if (CE) begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------------------------------
	// transfer context and burst advance
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			type_r      <= CYC_INTACK;
			addr_r      <= 30'h0;
			be_r        <= 4'h0;
			wdata_r     <= 64'h0;
			par_r       <= 4'h0;
			beats_r     <= 3'h0;
			pseudo_r    <= 1'b0;
			lock_last_r <= 1'b0;
			fill_r      <= 1'b0;
			first_t2_r  <= 1'b0;
			ken_seen_r  <= 1'b0;
		end else if (CE) begin
			beats_r    <= beats_nxt;
			first_t2_r <= (state_r == DS_T1);
			if (start) begin
				type_r      <= cyc_type_e'(REQ_TYPE);
				addr_r      <= REQ_ADDR;
				be_r        <= REQ_BE;
				wdata_r     <= REQ_WDATA;
				par_r       <= lane_parity(REQ_WDATA[31:0]);
				pseudo_r    <= REQ_PSEUDO;
				lock_last_r <= REQ_LOCK_LAST;
				fill_r      <= ~REQ_TYPE[0] & (REQ_BEATS == `LINE_BEATS) & ~REQ_LOCK;
				ken_seen_r  <= 1'b0;
			end else begin
				if (first_t2_r & ~BUS.cacheable_in_n) begin
					ken_seen_r <= 1'b1;
				end
				if (beat_hit & ~eff_last) begin
					addr_r[3:2] <= addr_r[3:2] + 2'h1;
					wdata_r     <= {32'h0, wdata_r[63:32]};
					par_r       <= lane_parity(wdata_r[63:32]);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// bus control outputs
	// ----------------------------------------------------------------
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			ads_n_r    <= 1'b1;
			ctl_oe_r   <= 1'b1;
			addr_oe_r  <= 1'b1;
			hold_ack_r <= 1'b0;
			d_oe_r     <= 1'b0;
			final_n_r  <= 1'b1;
			multi_cycle_atomic_n_n_r  <= 1'b1;
			lock_n_r   <= 1'b1;
		end else if (CE) begin
			ads_n_r    <= ~(state_nxt == DS_T1);
			ctl_oe_r   <= (state_nxt != DS_HOLD);
			// address float leaves data and control active and ready still sampled
			addr_oe_r  <= (state_nxt != DS_HOLD) & ~BUS.addr_float_req;
			hold_ack_r <= (state_nxt == DS_HOLD);
			d_oe_r     <= bus_on_nxt & write_nxt;
			// writes never burst, so every write beat is the final one
			final_n_r  <= ~(bus_on_nxt & (write_nxt | (beats_nxt == 3'h1)));
			multi_cycle_atomic_n_n_r  <= ~(bus_on_nxt & pseudo_nxt & (beats_nxt > 3'h1));
			if (start & REQ_LOCK) begin
				lock_n_r <= 1'b0;
			end else if (xfer_end & lock_last_r) begin
				lock_n_r <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// read parity check and read return
	// ----------------------------------------------------------------
	assign lane_mask = be_r & width_mask(BUS.width_sel_byte_n, BUS.width_sel_half_n);
	assign par_bad   = |((lane_parity(BUS.data_lanes) ^ BUS.lane_parity_bits) & lane_mask);

	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			parity_fault_n_n_r  <= 1'b1;
			RD_VALID  <= 1'b0;
			RD_DATA   <= 32'h0;
			DONE      <= 1'b0;
			REQ_READY <= 1'b0;
		end else if (CE) begin
			// a fault is reported on the pin only; nothing else reacts to it
			parity_fault_n_n_r  <= ~(beat_hit & ~type_r[0] & (type_r != CYC_INTACK) & par_bad);
			RD_VALID  <= beat_hit & ~type_r[0];
			if (beat_hit) begin
				RD_DATA <= BUS.data_lanes;
			end
			DONE      <= xfer_end;
			REQ_READY <= (state_nxt == DS_IDLE);
		end
	end

	assign BUS.cpu_d                = wdata_r[31:0];
	assign BUS.cpu_dp               = par_r;
	assign BUS.cpu_d_oe             = d_oe_r;
	assign BUS.m_io                 = type_r[2];
	assign BUS.d_c                  = type_r[1];
	assign BUS.w_r                  = type_r[0];
	assign BUS.addr_strobe_n        = ads_n_r;
	assign BUS.final_beat_n         = final_n_r;
	assign BUS.multi_cycle_atomic_n = multi_cycle_atomic_n_n_r;
	assign BUS.atomic_seq_n         = lock_n_r;
	assign BUS.word_addr_lines      = addr_r;
	assign BUS.lane_enables_n       = ~be_r;
	assign BUS.ctl_oe               = ctl_oe_r;
	assign BUS.addr_oe              = addr_oe_r;
	assign BUS.hold_ack             = hold_ack_r;
	assign BUS.parity_fault_n       = parity_fault_n_n_r;
endmodule

// ==== local_bus_props.sv ====
// bus checks on the wires between the processor end and the system end
`timescale 1ns/10ps
module local_bus_props (
	// clock and reset
	input wire logic        REF_CLK,
	input wire logic        RSTN,
	// cycle control
	input wire logic        m_io,
	input wire logic        d_c,
	input wire logic        w_r,
	input wire logic        addr_strobe_n,
	input wire logic        final_beat_n,
	input wire logic        multi_cycle_atomic_n,
	input wire logic        atomic_seq_n,
	input wire logic [31:2] word_addr_lines,
	input wire logic [3:0]  lane_enables_n,
	input wire logic        hold_ack,
	input wire logic        parity_fault_n,
	// data and answers
	input wire logic        cpu_d_oe,
	input wire logic [31:0] data_lanes,
	input wire logic [3:0]  lane_parity_bits,
	input wire logic        rdy_n,
	input wire logic        burst_ready_n,
	input wire logic        width_sel_byte_n,
	input wire logic        width_sel_half_n
);
	logic [3:0] lane_odd;
	logic [3:0] wmask;
	logic       bad_par;
	logic       rdy_any;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);

	// --------
	// parity on the wire
	// --------
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_odd[i] = ^{data_lanes[8*i +: 8], lane_parity_bits[i]};
		end
	end
	// narrow widths hide upper lanes, so bad bits there must not fault
	assign wmask   = !width_sel_byte_n ? 4'h1 : (!width_sel_half_n ? 4'h3 : 4'hf);
	assign bad_par = |(lane_odd & ~lane_enables_n & wmask) && ({m_io, d_c, w_r} != 3'h0);
	assign rdy_any = !rdy_n || !burst_ready_n;

	// --------
	// framing
	// --------
	sequence cyc_open;
		!addr_strobe_n;
	endsequence
	sequence cyc_close;
		(rdy_n && burst_ready_n) ##[1:40] (!rdy_n || (!burst_ready_n && !final_beat_n));
	endsequence

	strobe_single_a: assert property (cyc_open |=> addr_strobe_n)
		else $error("strobe too long");
	cycle_close_a: assert property (cyc_open |-> cyc_close)
		else $error("cycle not closed");
	type_hold_a: assert property (cyc_open |=> $stable({m_io, d_c, w_r}))
		else $error("type moved");
	no_reserved_a: assert property (cyc_open |-> {m_io, d_c, w_r} != 3'h5)
		else $error("reserved type");
	read_float_a: assert property (cpu_d_oe |-> w_r && !hold_ack)
		else $error("data driven on read");
	write_parity_a: assert property (cpu_d_oe |-> lane_odd == 4'h0)
		else $error("odd write parity");
	parity_fault_n_value_a: assert property (rdy_any && !w_r && addr_strobe_n |=> parity_fault_n == !$past(bad_par))
		else $error("parity status wrong");
	parity_fault_n_quiet_a: assert property (!parity_fault_n |-> $past(rdy_any && !w_r))
		else $error("stray parity fault");
	grant_lock_a: assert property (hold_ack |-> atomic_seq_n)
		else $error("grant in lock");
	pseudo_final_a: assert property (!addr_strobe_n && !multi_cycle_atomic_n && !w_r |-> final_beat_n)
		else $error("atomic and final on read");
	burst_step_a: assert property (!burst_ready_n && rdy_n && final_beat_n && addr_strobe_n |=>
		addr_strobe_n && word_addr_lines[3:2] == $past(word_addr_lines[3:2]) + 2'h1)
		else $error("burst address stuck");
	lock_start_a: assert property ($fell(atomic_seq_n) |-> !addr_strobe_n)
		else $error("lock off strobe");
endmodule

// ==== tb_top.sv ====
// self-checking bench joining both ends of the local bus
`timescale 1ns/10ps
module tb_top
	import bus_pkg::*;
;
	// --------
	// stimulus and observation
	// --------
	logic        ref_clk = 1'b0;
	logic        rstn = 1'b0;
	logic        ce = 1'b1;
	logic        req_valid = 1'b0;
	logic [2:0]  req_type = 3'h0;
	logic [31:2] req_addr = 30'h0;
	logic [3:0]  req_be = 4'hf;
	logic [63:0] req_wdata = 64'h0;
	logic [2:0]  req_beats = 3'h1;
	logic        req_pseudo = 1'b0;
	logic        req_lock = 1'b0;
	logic        req_lock_last = 1'b0;
	logic [3:0]  wait_states = 4'h0;
	logic [3:0]  par_flip = 4'h0;
	logic        burst_en = 1'b0;
	logic        ken_en = 1'b0;
	logic        hold_in = 1'b0;
	logic        float_in = 1'b0;
	logic        width_byte = 1'b0;
	logic        width_half = 1'b0;
	logic        req_ready, rd_valid, done, cap_valid, par_fault, hold_ack;
	logic [31:0] rd_data;
	logic [2:0]  cap_type;
	logic [31:2] cap_addr;
	logic [2:0]  last_type = 3'h0;
	logic [31:0] rdq[$];
	int          err_count = 0;
	int          n_tests = 0;
	int          pf_n = 0;
	cyc_type_e   codes[6] = '{CYC_IO_WR, CYC_IO_RD, CYC_HALT, CYC_INTACK, CYC_CODE_RD, CYC_MEM_RD};
	logic [3:0]  pbe[6] = '{4'hf, 4'h1, 4'hf, 4'hf, 4'hf, 4'h3};
	logic [3:0]  pfl[6] = '{4'h1, 4'h8, 4'h2, 4'h4, 4'h2, 4'h4};
	logic [1:0]  pws[6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0};
	int          pexp[6] = '{1, 0, 0, 0, 1, 0};

	local_bus_if lb();

	cpu_bus_end cpu_bus_end_i (.REF_CLK(ref_clk), .RSTN(rstn), .CE(ce), .BUS(lb.cpu),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_TYPE(req_type), .REQ_ADDR(req_addr),
		.REQ_BE(req_be), .REQ_WDATA(req_wdata), .REQ_BEATS(req_beats), .REQ_PSEUDO(req_pseudo),
		.REQ_LOCK(req_lock), .REQ_LOCK_LAST(req_lock_last), .RD_VALID(rd_valid), .RD_DATA(rd_data), .DONE(done));

	sys_bus_end #(.MEM_AW(4)) sys_bus_end_i (.REF_CLK(ref_clk), .RSTN(rstn), .CE(ce), .BUS(lb.sys),
		.WAIT_STATES(wait_states), .BURST_EN(burst_en), .KEN_EN(ken_en), .PAR_FLIP(par_flip),
		.HOLD_IN(hold_in), .FLOAT_IN(float_in), .WIDTH_BYTE(width_byte), .WIDTH_HALF(width_half),
		.INTACK_VEC(8'h5a), .CAP_VALID(cap_valid), .CAP_TYPE(cap_type), .CAP_ADDR(cap_addr),
		.PAR_FAULT(par_fault), .HOLD_ACK(hold_ack));

	local_bus_props local_bus_props_i (.REF_CLK(ref_clk), .RSTN(rstn), .m_io(lb.m_io), .d_c(lb.d_c),
		.w_r(lb.w_r), .addr_strobe_n(lb.addr_strobe_n), .final_beat_n(lb.final_beat_n),
		.multi_cycle_atomic_n(lb.multi_cycle_atomic_n), .atomic_seq_n(lb.atomic_seq_n),
		.word_addr_lines(lb.word_addr_lines), .lane_enables_n(lb.lane_enables_n), .hold_ack(lb.hold_ack),
		.parity_fault_n(lb.parity_fault_n), .cpu_d_oe(lb.cpu_d_oe), .data_lanes(lb.data_lanes),
		.lane_parity_bits(lb.lane_parity_bits), .rdy_n(lb.rdy_n), .burst_ready_n(lb.burst_ready_n),
		.width_sel_byte_n(lb.width_sel_byte_n), .width_sel_half_n(lb.width_sel_half_n));

	always #20 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		if (rd_valid === 1'b1) rdq.push_back(rd_data);
		if (par_fault === 1'b1) pf_n++;
		if (cap_valid === 1'b1) last_type <= cap_type;
	end

	// --------
	// tasks
	// --------
	function automatic logic [31:0] wv(input int k);
		return 32'h9c3b71e0 + 32'(k) * 32'h11111111;
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// request held until taken, then wait for done; parity status lands two clocks later
	task automatic do_req(input logic [2:0] t, input int a, input logic [3:0] be, input logic [63:0] wd,
		input logic [2:0] nb, input logic ps, input logic lk, input logic ll);
		int n;
		rdq.delete();
		pf_n = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		{req_type, req_addr, req_be, req_wdata, req_beats, req_pseudo, req_lock, req_lock_last} <=
			{t, 30'(a), be, wd, nb, ps, lk, ll};
		@(posedge ref_clk);
		for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(posedge ref_clk);
		req_valid <= 1'b0;
		for (n = 0; n < 200 && done !== 1'b1; n++) @(posedge ref_clk);
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic give_verdict();
		if (err_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge ref_clk);
		err_count++;
		$display("BAD watchdog expected done seen hang");
		give_verdict();
	end

	// --------
	// scenarios
	// --------
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int k = 0; k < 8; k++) begin
			do_req(CYC_MEM_WR, k, 4'hf, {32'h0, wv(k)}, 3'h1, 1'b0, 1'b0, 1'b0);
			chk("write type", 32'(last_type), 32'(CYC_MEM_WR));
			chk("write addr", 32'(cap_addr), 32'(k));
		end
		// every lane flipped: only checked read kinds may fault
		par_flip <= 4'hf;
		foreach (codes[i]) begin
			do_req(codes[i], 7, 4'hf, {32'h0, wv(7)}, 3'h1, 1'b0, 1'b0, 1'b0);
			chk("cycle type", 32'(last_type), 32'(codes[i]));
			chk("fault count", pf_n, (codes[i][0] == 1'b0 && codes[i] != CYC_INTACK) ? 1 : 0);
		end
		for (int i = 0; i < 6; i++) begin
			{width_half, width_byte, par_flip, wait_states} <= {pws[i], pfl[i], 4'(i)};
			do_req(CYC_MEM_RD, 2, pbe[i], 64'h0, 3'h1, 1'b0, 1'b0, 1'b0);
			chk("parity fault", pf_n, pexp[i]);
			chk("read lane 0", {24'h0, rdq[0][7:0]}, wv(2) & 32'hff);
		end
		{ken_en, burst_en, par_flip, width_half, width_byte, wait_states} <= {2'h3, 4'h0, 2'h0, 4'h0};
		do_req(CYC_CODE_RD, 2, 4'hf, 64'h0, 3'h4, 1'b1, 1'b0, 1'b0);
		chk("fill beats", rdq.size(), 4);
		for (int i = 0; i < 4; i++) chk("fill data", rdq[i], wv((i + 2) % 4));
		ken_en <= 1'b0;
		do_req(CYC_CODE_RD, 1, 4'hf, 64'h0, 3'h4, 1'b1, 1'b0, 1'b0);
		chk("uncached fill", rdq.size(), 1);
		chk("uncached data", rdq[0], wv(1));
		do_req(CYC_MEM_WR, 4, 4'hf, {wv(9), wv(8)}, 3'h2, 1'b1, 1'b0, 1'b0);
		{float_in, wait_states} <= {1'b1, 4'h2};
		do_req(CYC_MEM_RD, 4, 4'hf, 64'h0, 3'h2, 1'b1, 1'b0, 1'b0);
		chk("pseudo beat 0", rdq[0], wv(8));
		chk("pseudo beat 1", rdq[1], wv(9));
		float_in <= 1'b0;
		// locked read then hold asked: no grant until the locked write ends
		do_req(CYC_MEM_RD, 0, 4'hf, 64'h0, 3'h1, 1'b0, 1'b1, 1'b0);
		hold_in <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("hold in lock", hold_ack, 1'b0);
		do_req(CYC_MEM_WR, 0, 4'hf, {32'h0, wv(0)}, 3'h1, 1'b0, 1'b1, 1'b1);
		repeat (4) @(posedge ref_clk);
		chk("hold after lock", hold_ack, 1'b1);
		hold_in <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("hold released", hold_ack, 1'b0);
		give_verdict();
	end
endmodule
